//--- hw/sdt_ctrl.sv
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module sdt_ctrl
    import sdt_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,              // power-on reset
    input wire logic manual_rst_n,      // manual reset: timing register keeps contents
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // memory side events
    input wire logic ext_wait_pin,      // external wait input, asynchronous
    input wire logic bus_cycle_active,  // external bus cycle in progress
    input wire logic refresh_req,       // periodic refresh request pulse
    input wire logic act_req,           // bank-active wanted
    input wire logic pre_one_evt,       // single-bank precharge issued
    input wire logic write_end_evt,     // write cycle ended
    input wire logic sref_exit_req,     // leave self-refresh
    input wire logic [25:0] cpu_addr,   // address to multiplex
    // outputs
    output logic act_grant,             // bank-active may go this cycle
    output logic refresh_go,            // refresh cycle issued
    output logic self_refresh_active,   // memory in self-refresh
    output logic wait_honoured,         // synchronised wait pin, gated per mode
    output logic [13:0] row_addr,       // multiplexed row address
    output sdt_cfg_t cfg                // decoded timing for the bus sequencer
);
    // reset release through two flops
    logic [1:0] rst_sync_r;
    logic rst_n;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // manual reset synchronised likewise; it clears only non-retained state
    logic [1:0] man_sync_r;
    logic run_n;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            man_sync_r <= 2'h0;
        end else begin
            man_sync_r <= {man_sync_r[0], manual_rst_n};
        end
    end
    assign run_n = man_sync_r[1];

    // wait pin through two flops before use
    logic [1:0] wait_sync_r;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_sync_r <= 2'h0;
        end else begin
            wait_sync_r <= {wait_sync_r[0], ext_wait_pin};
        end
    end

    // registers
    logic [15:0] wait_ctrl_r;   // area wait control
    logic [15:0] mem_timing_r;  // memory_timing_control
    logic [1:0] area_cfg_r;     // bit0 area 2 sdram, bit1 area 3 sdram

    // axi write path: address and data captured independently
    logic aw_held_r;
    logic w_held_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    wire do_write = aw_held_r && w_held_r && !bvalid_r;
    wire wr_wait = (aw_addr_r == SDT_WAIT_CTRL_ADDR);
    wire wr_timing = (aw_addr_r == SDT_MEM_TIMING_ADDR);
    wire wr_area = (aw_addr_r == SDT_AREA_CFG_ADDR);
    wire wr_ok = wr_wait || wr_timing || wr_area || (aw_addr_r == SDT_STATUS_ADDR);
    wire [15:0] wmask16 = {{8{w_strb_r[1]}}, {8{w_strb_r[0]}}};

    assign s_axi_awready = !aw_held_r;
    assign s_axi_wready = !w_held_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    // write channel capture and response
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= 2'h0;
        end else begin
            if (s_axi_awvalid && !aw_held_r) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_held_r) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (do_write) begin
                bvalid_r <= 1'b1;
                bresp_r <= wr_ok ? 2'h0 : 2'h2; // slverr on unmapped
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
            end
        end
    end

    // wait control and area select; these follow any reset
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_ctrl_r <= SDT_WAIT_CTRL_RST;
            area_cfg_r <= SDT_AREA_CFG_RST;
        end else if (!run_n) begin
            wait_ctrl_r <= SDT_WAIT_CTRL_RST;
            area_cfg_r <= SDT_AREA_CFG_RST;
        end else if (do_write) begin
            if (wr_wait) begin
                wait_ctrl_r <= (wait_ctrl_r & ~wmask16) | (w_data_r[15:0] & wmask16);
            end
            if (wr_area && w_strb_r[0]) begin
                area_cfg_r <= w_data_r[1:0];
            end
        end
    end

    // timing register: power-on reset only, manual reset does not touch it
    // bit 0 is never stored
    wire [15:0] tm_mask = wmask16 & SDT_MEM_TIMING_WMASK;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_timing_r <= SDT_MEM_TIMING_RST;
        end else if (do_write && wr_timing) begin
            mem_timing_r <= (mem_timing_r & ~tm_mask) | (w_data_r[15:0] & tm_mask);
        end
    end

    // field decode
    wire [1:0] tpc_code = mem_timing_r[SDT_TPC_LSB +: 2];
    wire [1:0] rcd_code = mem_timing_r[SDT_RCD_LSB +: 2];
    wire [1:0] trwl_code = mem_timing_r[SDT_TRWL_LSB +: 2];
    wire [1:0] tras_code = mem_timing_r[SDT_TRAS_LSB +: 2];
    wire [3:0] amx_code = mem_timing_r[SDT_AMX_LSB +: 4];
    wire [1:0] a2w_code = wait_ctrl_r[SDT_A2W_LSB +: 2];
    wire [2:0] a0w_code = wait_ctrl_r[SDT_A0W_LSB +: 3];

    // precharge: 1..4 normal, one less after all_bank_precharge_cmd/bank-active pre, 3n+2 after self-refresh
    assign cfg.tpc = {2'h0, tpc_code} + 4'h1;
    assign cfg.tpc_short = {2'h0, tpc_code};
    assign cfg.tpc_sref = {2'h0, tpc_code} + {1'b0, tpc_code, 1'b0} + 4'h2;
    assign cfg.rcd = {2'h0, rcd_code} + 4'h1;
    // code 11 is reserved; it decodes to 4 but software must not use it
    assign cfg.trwl = {2'h0, trwl_code} + 4'h1;
    assign cfg.tras = {2'h0, tras_code} + 4'h2;
    assign cfg.bank_active = mem_timing_r[SDT_BANK_MODE_BIT];
    assign cfg.refresh_on = mem_timing_r[SDT_REFRESH_ENABLE_BIT];
    assign cfg.self_refresh = mem_timing_r[SDT_REFRESH_KIND_SELECT_BIT];

    // cas latency: 00 and 01 both give 1
    assign cfg.cas_lat = (a2w_code == 2'h0) ? 2'h1 : a2w_code;

    // area 0 wait tables
    logic [3:0] first_tab;
    logic [3:0] burst_tab;
    always_comb begin
        case (a0w_code)
            3'h0: begin first_tab = 4'h0; burst_tab = 4'h2; end
            3'h1: begin first_tab = 4'h1; burst_tab = 4'h2; end
            3'h2: begin first_tab = 4'h2; burst_tab = 4'h3; end
            3'h3: begin first_tab = 4'h3; burst_tab = 4'h4; end
            3'h4: begin first_tab = 4'h4; burst_tab = 4'h4; end
            3'h5: begin first_tab = 4'h6; burst_tab = 4'h6; end
            3'h6: begin first_tab = 4'h8; burst_tab = 4'h8; end
            default: begin first_tab = 4'ha; burst_tab = 4'ha; end
        endcase
    end
    assign cfg.first_wait = first_tab;
    assign cfg.burst_pitch = burst_tab;
    assign cfg.first_wait_pin = (a0w_code != 3'h0);

    // row start bit from the address-multiplex code
    logic [3:0] row_shift;
    always_comb begin
        case (amx_code)
            4'hd: row_shift = 4'ha;
            4'he: row_shift = 4'hb;
            4'h4: row_shift = 4'h9;
            4'h5: row_shift = 4'ha;
            4'h7: row_shift = 4'h9;
            default: row_shift = 4'h0; // initial or reserved codes
        endcase
    end
    assign cfg.row_shift = row_shift;
    // the start bit lands on address pin 1
    wire [25:0] shifted = cpu_addr >> row_shift;
    assign row_addr = {shifted[12:0], 1'b0};

    // wait pin use: first cycle honours it unless zero waits; burst always
    logic in_burst_r;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            in_burst_r <= 1'b0;
        end else begin
            in_burst_r <= bus_cycle_active && (in_burst_r || write_end_evt);
        end
    end
    assign wait_honoured = wait_sync_r[1] && (in_burst_r || cfg.first_wait_pin);

    // refresh sequencing
    typedef enum logic [1:0] {SDT_IDLE, SDT_REF_PEND, SDT_SREF_PEND, SDT_SREF} sdt_ref_t;
    sdt_ref_t ref_st_r;
    sdt_ref_t ref_st_nxt;
    logic ref_go_r;
    wire ref_go_nxt = (ref_st_r == SDT_REF_PEND) && !bus_cycle_active;
    always_comb begin
        ref_st_nxt = ref_st_r;
        case (ref_st_r)
            SDT_IDLE: begin
                if (cfg.refresh_on && cfg.self_refresh) begin
                    ref_st_nxt = SDT_SREF_PEND;
                end else if (cfg.refresh_on && refresh_req) begin
                    ref_st_nxt = SDT_REF_PEND;
                end
            end
            // hold the request until the bus cycle ends
            SDT_REF_PEND: begin
                if (!bus_cycle_active) begin
                    ref_st_nxt = SDT_IDLE;
                end
            end
            // enter self-refresh only after the bus cycle ends
            SDT_SREF_PEND: begin
                if (!bus_cycle_active) begin
                    ref_st_nxt = SDT_SREF;
                end
            end
            // requests are ignored while here
            SDT_SREF: begin
                if (sref_exit_req || !cfg.self_refresh || !cfg.refresh_on) begin
                    ref_st_nxt = SDT_IDLE;
                end
            end
            default: ref_st_nxt = SDT_IDLE;
        endcase
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_st_r <= SDT_IDLE;
            ref_go_r <= 1'b0;
        end else begin
            ref_st_r <= ref_st_nxt;
            ref_go_r <= ref_go_nxt;
        end
    end
    assign refresh_go = ref_go_r;
    assign self_refresh_active = (ref_st_r == SDT_SREF);
    wire sref_leaving = (ref_st_r == SDT_SREF) && (ref_st_nxt == SDT_IDLE);

    // bank-active hold-off: the latest event reloads the timer
    logic [4:0] hold_cnt;
    logic hold_load;
    always_comb begin
        hold_load = 1'b1;
        hold_cnt = 5'h00;
        if (sref_leaving) begin
            hold_cnt = {1'b0, cfg.tpc_sref};
        end else if (ref_go_r) begin
            hold_cnt = {1'b0, cfg.tpc_short} + {1'b0, cfg.tras};
        end else if (write_end_evt) begin
            hold_cnt = {1'b0, cfg.tpc} + {1'b0, cfg.trwl};
        end else if (pre_one_evt) begin
            // bank-active single precharge is one shorter
            hold_cnt = {1'b0, cfg.bank_active ? cfg.tpc_short : cfg.tpc};
        end else begin
            hold_load = 1'b0;
        end
    end

    logic hold_busy;
    sdt_timer u_hold (
        .clk(sys_clk),
        .rst_n(rst_n),
        .load(hold_load),
        .count(hold_cnt),
        .busy(hold_busy)
    );
    assign act_grant = act_req && !hold_busy && !hold_load && (ref_st_r == SDT_IDLE);

    // axi read path
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    wire [31:0] status_word = {26'h0, ref_st_r, hold_busy, ref_go_r, 2'h0};
    logic [31:0] rd_mux;
    logic rd_ok;
    always_comb begin
        rd_ok = 1'b1;
        case (s_axi_araddr)
            SDT_WAIT_CTRL_ADDR: rd_mux = {16'h0, wait_ctrl_r};
            SDT_MEM_TIMING_ADDR: rd_mux = {16'h0, mem_timing_r};
            SDT_STATUS_ADDR: rd_mux = status_word;
            SDT_AREA_CFG_ADDR: rd_mux = {30'h0, area_cfg_r};
            default: begin rd_mux = 32'h0000_0000; rd_ok = 1'b0; end
        endcase
    end
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= 2'h0;
        end else if (s_axi_arvalid && !rvalid_r) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_mux;
            rresp_r <= rd_ok ? 2'h0 : 2'h2;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end
endmodule : sdt_ctrl

//--- hw/sdt_pkg.sv
package sdt_pkg;

    // register byte addresses on the axi4-lite slave
    localparam logic [7:0] SDT_WAIT_CTRL_ADDR = 8'h00;   // area 2 / area 0 wait fields
    localparam logic [7:0] SDT_MEM_TIMING_ADDR = 8'h04;  // memory_timing_control
    localparam logic [7:0] SDT_STATUS_ADDR = 8'h08;      // live sequencer state
    localparam logic [7:0] SDT_AREA_CFG_ADDR = 8'h0c;    // area 2/3 sdram select

    // reset values
    localparam logic [15:0] SDT_WAIT_CTRL_RST = 16'h001f;
    localparam logic [15:0] SDT_MEM_TIMING_RST = 16'h0000;
    localparam logic [1:0] SDT_AREA_CFG_RST = 2'h0;

    // wait control field positions
    localparam int SDT_A2W_LSB = 3;
    localparam int SDT_A0W_LSB = 0;

    // memory_timing_control field positions
    localparam int SDT_TPC_LSB = 14;
    localparam int SDT_RCD_LSB = 12;
    localparam int SDT_TRWL_LSB = 10;
    localparam int SDT_TRAS_LSB = 8;
    localparam int SDT_BANK_MODE_BIT = 7;
    localparam int SDT_AMX_LSB = 3;
    localparam int SDT_REFRESH_ENABLE_BIT = 2;
    localparam int SDT_REFRESH_KIND_SELECT_BIT = 1;
    localparam logic [15:0] SDT_MEM_TIMING_WMASK = 16'hfffe;

    // width of each decoded cycle count in sdt_cfg_t except the 2-bit cas_lat; the hold-off timer count is 5 bits
    localparam int SDT_CW = 4;

    // decoded settings handed to the sequencer
    typedef struct packed {
        logic [3:0] tpc;        // normal precharge interval
        logic [3:0] tpc_short;  // one fewer, after refresh all_bank_precharge_cmd or bank-active pre
        logic [3:0] tpc_sref;   // after self-refresh exit
        logic [3:0] rcd;        // ras to cas delay
        logic [3:0] trwl;       // write recovery
        logic [3:0] tras;       // refresh recovery
        logic [3:0] first_wait; // area 0 first-cycle waits
        logic [3:0] burst_pitch;// area 0 states per burst item
        logic first_wait_pin;   // wait input honoured in first cycle
        logic [1:0] cas_lat;    // area 2 cas latency
        logic bank_active;
        logic [3:0] row_shift;  // address bit the row starts at
        logic refresh_on;
        logic self_refresh;
    } sdt_cfg_t;

    // sequencer command requests
    typedef struct packed {
        logic activate;      // bank-active wanted
        logic precharge_all; // all-bank precharge issued
        logic precharge_one; // single-bank precharge issued
        logic write_end;     // write cycle finished
        logic auto_ref;      // auto-refresh command issued
        logic sref_exit;     // leaving self-refresh
    } sdt_evt_t;

endpackage : sdt_pkg

//--- hw/sdt_timer.sv
`timescale 1ns/1ps
// down counter that gates the next bank-active command
module sdt_timer
    import sdt_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [4:0] count,
    output logic busy
);
    logic [4:0] cnt_r; // remaining hold-off cycles
    logic [4:0] cnt_nxt;

    // a load restarts the count; otherwise count down to zero
    assign cnt_nxt = load ? count : (cnt_r != 5'h00 ? cnt_r - 5'h01 : 5'h00);
    assign busy = (cnt_r != 5'h00);

    // counter state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 5'h00;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule : sdt_timer

//--- testbench/sdt_ctrl_monitor.sv
`timescale 1ns/1ps
// sees only top ports; bound from the bench
module sdt_ctrl_monitor
    import sdt_pkg::*;
(
    input logic sys_clk,
    input logic rstn,
    input logic write_end_evt,
    input logic bus_cycle_active,
    input logic [25:0] cpu_addr,
    input logic act_grant,
    input logic refresh_go,
    input logic self_refresh_active,
    input logic [13:0] row_addr,
    input sdt_cfg_t cfg
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // hold-off floors at the shortest settings
    sequence s_write_hold;
        !act_grant [*2];
    endsequence
    sequence s_ref_hold;
        !act_grant [*3];
    endsequence
    a_write_holdoff: assert property (write_end_evt |=> s_write_hold)
        else $error("early activate after write");
    a_refresh_holdoff: assert property (refresh_go |-> s_ref_hold)
        else $error("early activate after refresh");
    a_refresh_after_bus: assert property (bus_cycle_active |=> !refresh_go)
        else $error("refresh in bus cycle");
    a_sref_quiet: assert property (self_refresh_active && $past(self_refresh_active) |-> !refresh_go)
        else $error("refresh in self-refresh");
    a_sref_entry: assert property (bus_cycle_active && !self_refresh_active |=> !self_refresh_active)
        else $error("self-refresh in bus cycle");
    a_first_pin: assert property (cfg.first_wait_pin == (cfg.first_wait != 4'h0))
        else $error("first-cycle pin use wrong");
    a_burst_pitch: assert property (cfg.burst_pitch == ((cfg.first_wait < 4'h2) ? 4'h2 :
        (cfg.first_wait < 4'h4) ? cfg.first_wait + 4'h1 : cfg.first_wait))
        else $error("burst pitch wrong");
    a_tpc_short: assert property (cfg.tpc_short == cfg.tpc - 4'h1)
        else $error("short precharge wrong");
    a_tpc_sref: assert property (cfg.tpc_sref == cfg.tpc + cfg.tpc + cfg.tpc - 4'h1)
        else $error("self-refresh precharge wrong");
    a_cas_range: assert property (cfg.cas_lat != 2'h0)
        else $error("cas latency zero");
    a_row_start: assert property (!row_addr[0] && row_addr[1] == cpu_addr[cfg.row_shift])
        else $error("row start bit wrong");
endmodule : sdt_ctrl_monitor

//--- testbench/sdt_mem_model.sv
`timescale 1ns/1ps
// far-side memory: one write access per go pulse
module sdt_mem_model
(
    input logic sys_clk,
    input logic rstn,
    input logic go_write,
    input logic act_grant,
    input logic bank_active,
    output logic act_req,
    output logic bus_cycle_active,
    output logic write_end_evt,
    output logic pre_one_evt
);
    logic [3:0] step_r; // 0 idle, 1 waiting for grant, 2..7 data phase
    // the row is opened only on a grant, never ahead of it
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            step_r <= 4'h0;
            act_req <= 1'b0;
            bus_cycle_active <= 1'b0;
            write_end_evt <= 1'b0;
            pre_one_evt <= 1'b0;
        end else begin
            write_end_evt <= (step_r == 4'h7);
            pre_one_evt <= (step_r == 4'h6) & bank_active;
            if (step_r == 4'h0) begin
                act_req <= go_write;
                bus_cycle_active <= go_write;
                step_r <= {3'h0, go_write};
            end else if (step_r == 4'h1) begin
                act_req <= ~act_grant;
                step_r <= act_grant ? 4'h2 : 4'h1;
            end else begin
                bus_cycle_active <= (step_r != 4'h7);
                step_r <= (step_r == 4'h7) ? 4'h0 : step_r + 4'h1;
            end
        end
    end
endmodule : sdt_mem_model

//--- testbench/sdt_ctrl_bench.sv
`timescale 1ns/1ps
// axi master, register shadows, far-side model
module sdt_ctrl_bench
    import sdt_pkg::*;
;
    logic sys_clk, rstn, manual_rst_n, go_write, ext_wait_pin, refresh_req, sref_exit_req;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [25:0] cpu_addr;
    logic act_req, bus_cycle_active, pre_one_evt, write_end_evt;
    logic act_grant, refresh_go, self_refresh_active, wait_honoured;
    logic [13:0] row_addr;
    logic [15:0] lfsr, sh_wait, sh_tim; // lfsr and shadows
    sdt_cfg_t cfg;
    int n_errors, check_count, cyc, n_go, n;
    int fw[8] = '{0, 1, 2, 3, 4, 6, 8, 10}; // first-cycle waits per code
    int bp[8] = '{2, 2, 3, 4, 4, 6, 8, 10}; // burst states per code
    int amx[5] = '{13, 14, 4, 5, 7}; // listed multiplex codes
    int st[5] = '{10, 11, 9, 10, 9}; // row start bit for each
    sdt_ctrl i_dut (.sys_clk, .rstn, .manual_rst_n, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .ext_wait_pin, .bus_cycle_active, .refresh_req, .act_req, .pre_one_evt,
        .write_end_evt, .sref_exit_req, .cpu_addr, .act_grant, .refresh_go,
        .self_refresh_active, .wait_honoured, .row_addr, .cfg);
    sdt_mem_model i_mem (.sys_clk, .rstn, .go_write, .act_grant, .bank_active(cfg.bank_active),
        .act_req, .bus_cycle_active, .write_end_evt, .pre_one_evt);
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // refresh count and hang guard
    always @(posedge sys_clk) begin
        if (refresh_go === 1'b1) n_go <= n_go + 1;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            results();
        end
    end
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr_next
    task check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask : check
    task results();
        $display("comparisons %0d, mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : results
    // each channel holds until its ready is seen at a rising edge
    task axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axi_wr
    task axi_rd(input logic [7:0] a);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_rd
    // shadow model against the decoded settings
    task cmp_cfg();
        int a0, a2, t;
        a0 = sh_wait[2:0];
        a2 = sh_wait[4:3];
        t = sh_tim[15:14];
        check(cfg.cas_lat, (a2 < 2) ? 1 : a2);
        check(cfg.first_wait, fw[a0]);
        check(cfg.first_wait_pin, a0 != 0);
        check(cfg.burst_pitch, bp[a0]);
        check(cfg.tpc, t + 1);
        check(cfg.tpc_sref, 3 * t + 2);
        check(cfg.tpc_short, t);
        check(cfg.rcd, sh_tim[13:12] + 1);
        check(cfg.trwl, sh_tim[11:10] + 1);
        check(cfg.tras, sh_tim[9:8] + 2);
        check(cfg.bank_active, sh_tim[7]);
        check(cfg.refresh_on, sh_tim[2]);
    endtask : cmp_cfg
    task power_on();
        rstn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        sh_wait = 16'h001f;
    endtask : power_on
    // go held high: the model asks again as the write ends; count the hold-off
    task hold_len();
        n = 0;
        @(posedge sys_clk);
        go_write <= 1'b1;
        do @(negedge sys_clk); while (!write_end_evt);
        @(negedge sys_clk);
        while (!act_grant && n < 40) begin
            n++;
            @(negedge sys_clk);
        end
        @(posedge sys_clk);
        go_write <= 1'b0;
    endtask : hold_len
    initial begin
        {rstn, go_write, refresh_req, sref_exit_req, cpu_addr} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        manual_rst_n = 1'b1;
        ext_wait_pin = 1'b1;
        lfsr = 16'h003a;
        sh_tim = 16'h0000;
        power_on();
        axi_rd(SDT_WAIT_CTRL_ADDR);
        check(rd, 32'h1f);
        for (int j = 0; j < 8; j++) begin
            sh_wait = 16'(j | (((7 - j) & 3) << 3));
            axi_wr(SDT_WAIT_CTRL_ADDR, {16'h0, sh_wait});
            repeat (3) @(negedge sys_clk);
            check(wait_honoured, j != 0);
            cmp_cfg();
        end
        $display("wait code test done");
        for (int i = 0; i < 5; i++) begin
            power_on();
            axi_rd(SDT_MEM_TIMING_ADDR);
            check(rd, 32'h0);
            // written once; bank-active only with legal code and no sdram pair
            sh_tim = 16'(((i % 4) << 14) | (((i + 1) % 4) << 12) | ((i % 3) << 10)
                | (((i + 2) % 4) << 8) | ((i == 4) << 7) | (amx[i] << 3) | 1);
            axi_wr(SDT_MEM_TIMING_ADDR, {16'h0, sh_tim});
            sh_tim = sh_tim & 16'hfffe;
            axi_rd(SDT_MEM_TIMING_ADDR);
            check(rd, {16'h0, sh_tim});
            lfsr = lfsr_next(lfsr);
            cpu_addr <= {lfsr[9:0], lfsr};
            @(negedge sys_clk);
            check(row_addr, 14'((cpu_addr >> st[i]) << 1));
            cmp_cfg();
            hold_len();
            check(n, (i % 4) + (i % 3) + 2);
            $display("timing set %0d test done", i);
        end
        manual_rst_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        manual_rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        sh_wait = 16'h001f;
        axi_rd(SDT_WAIT_CTRL_ADDR);
        check(rd, 32'h1f);
        axi_rd(SDT_MEM_TIMING_ADDR);
        check(rd, {16'h0, sh_tim});
        cmp_cfg();
        axi_rd(8'h40);
        check(rs, 2'h2);
        check(rd, 32'h0);
        axi_wr(8'h40, 32'hffff);
        check(rs, 2'h2);
        $display("manual reset test done");
        // refresh on, other fields rewritten unchanged
        sh_tim = sh_tim | 16'h0004;
        axi_wr(SDT_MEM_TIMING_ADDR, {16'h0, sh_tim});
        @(posedge sys_clk);
        go_write <= 1'b1;
        @(posedge sys_clk);
        go_write <= 1'b0;
        do @(negedge sys_clk); while (act_req || !bus_cycle_active);
        n = n_go;
        @(posedge sys_clk);
        refresh_req <= 1'b1;
        @(posedge sys_clk);
        refresh_req <= 1'b0;
        while (bus_cycle_active) @(negedge sys_clk);
        check(n_go, n);
        repeat (30) @(posedge sys_clk);
        check(n_go, n + 1);
        sh_tim = sh_tim | 16'h0006;
        axi_wr(SDT_MEM_TIMING_ADDR, {16'h0, sh_tim});
        repeat (20) @(negedge sys_clk);
        check(self_refresh_active, 1'b1);
        n = n_go;
        @(posedge sys_clk);
        refresh_req <= 1'b1;
        @(posedge sys_clk);
        refresh_req <= 1'b0;
        repeat (10) @(posedge sys_clk);
        check(n_go, n);
        sh_tim = sh_tim & 16'hfff9;
        axi_wr(SDT_MEM_TIMING_ADDR, {16'h0, sh_tim});
        repeat (20) @(negedge sys_clk);
        check(self_refresh_active, 1'b0);
        $display("refresh test done");
        results();
    end
endmodule : sdt_ctrl_bench
bind sdt_ctrl sdt_ctrl_monitor i_mon (.sys_clk, .rstn, .write_end_evt, .bus_cycle_active,
    .cpu_addr, .act_grant, .refresh_go, .self_refresh_active, .row_addr, .cfg);
